// *** pkg/frt_map.vh ***
// Register map, field positions, reset values and timing counts of the ride-through supervisor
// =============================================================================
// What this block does
// - Active only in mains parallel, generator parallel, or both, as configured.
// - Curve built from five point voltages and five time points after sag start.
// - Enabled and voltage below final recovery level starts event and event alarm.
// - During event, low voltage trip suppressed while voltage stays above curve.
// - Below curve during event, low voltage alarm after transient delay expires.
// - Event clears after final time point with voltage above final level, or at once if function goes inactive (once unrecovered, only on enable clear).
// - Not recovered at final time: alarm stays, suppression ends until new event.
// - While event active, listed protection trips and shutdowns are suppressed.
// - Warning alarms, low voltage warning included, are never suppressed.
// - Event counter increments by one on every event activation.
// - Counter readable by host, cleared by host maintenance reset.
`ifndef FRT_MAP_VH
`define FRT_MAP_VH

// =============================================================================
// Register byte offsets
`define FRT_OFS_CTRL 6'h00
`define FRT_OFS_VOLT_RETAINED 6'h04
`define FRT_OFS_VOLT_CLEARANCE 6'h08
`define FRT_OFS_VOLT_REC1 6'h0C
`define FRT_OFS_VOLT_REC2 6'h10
`define FRT_OFS_VOLT_FINAL 6'h14
`define FRT_OFS_TIME_CLEARANCE 6'h18
`define FRT_OFS_TIME_REC1 6'h1C
`define FRT_OFS_TIME_REC2 6'h20
`define FRT_OFS_TIME_REC3 6'h24
`define FRT_OFS_TIME_FINAL 6'h28
`define FRT_OFS_TRANSIENT 6'h2C
`define FRT_OFS_STATUS 6'h30
`define FRT_OFS_COUNT 6'h34
`define FRT_OFS_IRQ_STAT 6'h38
`define FRT_OFS_IRQ_MASK 6'h3C

// =============================================================================
// Control fields
`define FRT_CTRL_ENABLE 0
`define FRT_CTRL_MAINS 1
`define FRT_CTRL_GENS 2
`define FRT_CTRL_CNT_CLR 3

// Status fields
`define FRT_ST_EVENT 0
`define FRT_ST_SUPPRESS 1
`define FRT_ST_BELOW 2
`define FRT_ST_LV_ALARM 3
`define FRT_ST_UNRECOVERED 4
`define FRT_ST_ACTIVE 5

// Interrupt fields
`define FRT_IRQ_START 0
`define FRT_IRQ_LV_ALARM 1
`define FRT_IRQ_CLEARED 2
`define FRT_IRQ_UNRECOVERED 3
`define FRT_IRQ_W 4

// =============================================================================
// Reset values
`define FRT_CTRL_RST 3'h0
`define FRT_VOLT_RST 16'h0000
`define FRT_TIME_RST 16'h0000
`define FRT_IRQ_MASK_RST 4'h0

// =============================================================================
// Timing: curve times count in milliseconds
`define FRT_CLK_PERIOD_NS 5
`define FRT_MS_NS 1000000
`define FRT_MS_CYCLES (`FRT_MS_NS / `FRT_CLK_PERIOD_NS)

`endif

// *** hw/frt_curve_limit.v ***
// Stepped curve limit: voltage of the latest breakpoint reached
`timescale 1ns/10ps
`default_nettype none
module frt_curve_limit (
    // Clock and reset
    input wire core_clk_i,
    input wire reset_i,
    // Elapsed time and curve points
    input wire [15:0] elapsed_ms_i,
    input wire [15:0] t_clear_i,
    input wire [15:0] t_rec1_i,
    input wire [15:0] t_rec2_i,
    input wire [15:0] t_rec3_i,
    input wire [15:0] v_ret_i,
    input wire [15:0] v_clear_i,
    input wire [15:0] v_rec1_i,
    input wire [15:0] v_rec2_i,
    input wire [15:0] v_final_i,
    // Limit
    output reg [15:0] limit_o
);

    // Limit steps to the voltage of the latest breakpoint reached; a later breakpoint set lower lowers the curve
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            limit_o <= 16'h0000;
        end else if (elapsed_ms_i >= t_rec3_i) begin
            limit_o <= v_final_i;
        end else if (elapsed_ms_i >= t_rec2_i) begin
            limit_o <= v_rec2_i;
        end else if (elapsed_ms_i >= t_rec1_i) begin
            limit_o <= v_rec1_i;
        end else if (elapsed_ms_i >= t_clear_i) begin
            limit_o <= v_clear_i;
        end else begin
            limit_o <= v_ret_i;
        end
    end

endmodule // frt_curve_limit
`default_nettype wire

// *** hw/frt_delay_timer.v ***
// Millisecond delay timer, restarts whenever run drops
`timescale 1ns/10ps
`default_nettype none
module frt_delay_timer (
    // Clock and reset
    input wire core_clk_i,
    input wire reset_i,
    // Control
    input wire tick_i,
    input wire run_i,
    input wire [15:0] limit_i,
    // Result
    output reg done_o
);

    reg [15:0] count_ff;

    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_ff <= 16'h0000;
            done_o <= 1'b0;
        end else if (!run_i) begin
            count_ff <= 16'h0000;
            done_o <= 1'b0;
        end else begin
            if (tick_i && (count_ff < limit_i)) begin
                count_ff <= count_ff + 16'h0001;
            end
            done_o <= (count_ff >= limit_i);
        end
    end

endmodule // frt_delay_timer
`default_nettype wire

// *** hw/frt_supervisor.v ***
// Fault ride-through supervisor top with Avalon-MM register slave
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/10ps
`include "frt_map.vh"
`default_nettype none
module frt_supervisor #(
    parameter integer TICK_CYCLES = `FRT_MS_CYCLES
) (
    // Clock and reset
    input wire core_clk_i,
    input wire reset_i,
    // Avalon-MM slave
    input wire [5:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // Parallel status pins
    input wire mains_parallel_i,
    input wire gen_parallel_i,
    // Measured generator voltage
    input wire [15:0] gen_voltage_i,
    // Alarm requests from protections
    input wire gen_uv_trip_i,
    input wire [14:0] prot_trip_i,
    input wire gen_uv_warn_i,
    input wire [7:0] warn_i,
    // Alarm results
    output reg gen_uv_trip_o,
    output reg [14:0] prot_trip_o,
    output reg gen_uv_warn_o,
    output reg [7:0] warn_o,
    output reg ride_through_event_alarm_o,
    output reg gen_low_voltage_alarm_o,
    output reg suppress_active_o,
    output reg irq_o
);

    // =========================================================================
    // States
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_EVENT = 4'b0010;
    localparam [3:0] ST_HOLD = 4'b0100;
    localparam [3:0] ST_REARM = 4'b1000;

    localparam integer TICK_LAST_INT = TICK_CYCLES - 1;
    localparam [17:0] TICK_LAST = TICK_LAST_INT[17:0];

    // Byte-lane merge for 16-bit registers
    function [15:0] merge16;
        input [15:0] old_v;
        input [31:0] wdata;
        input [3:0] be;
        begin
            merge16[7:0] = be[0] ? wdata[7:0] : old_v[7:0];
            merge16[15:8] = be[1] ? wdata[15:8] : old_v[15:8];
        end
    endfunction

    // =========================================================================
    // Registers
    reg [2:0] ctrl_ff;
    reg [15:0] v_ret_ff;
    reg [15:0] v_clear_ff;
    reg [15:0] v_rec1_ff;
    reg [15:0] v_rec2_ff;
    reg [15:0] v_final_ff;
    reg [15:0] t_clear_ff;
    reg [15:0] t_rec1_ff;
    reg [15:0] t_rec2_ff;
    reg [15:0] t_rec3_ff;
    reg [15:0] t_final_ff;
    reg [15:0] transient_ff;
    reg [15:0] count_ff;
    reg [3:0] irq_stat_ff;
    reg [3:0] irq_mask_ff;
    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [17:0] presc_ff;
    reg tick_ff;
    reg [15:0] elapsed_ff;
    reg lv_alarm_ff;
    reg [2:0] mains_sync_ff;
    reg [2:0] gens_sync_ff;
    reg mains_ff;
    reg gens_ff;
    wire [15:0] curve_limit;
    wire transient_done;
    wire wr_acc;
    wire cnt_clr;
    wire fn_active;
    wire below_final;
    wire below_curve;
    wire in_event;
    wire ev_start;
    wire ev_cleared;
    wire ev_unrecovered;
    wire lv_rise;
    wire [3:0] irq_set;
    reg [31:0] nxt_rdata;

    // =========================================================================
    // Pin synchronisers: a change counts once stages two and three agree
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mains_sync_ff <= 3'h0;
            gens_sync_ff <= 3'h0;
            mains_ff <= 1'b0;
            gens_ff <= 1'b0;
        end else begin
            mains_sync_ff <= {mains_sync_ff[1:0], mains_parallel_i};
            gens_sync_ff <= {gens_sync_ff[1:0], gen_parallel_i};
            mains_ff <= (mains_sync_ff[1] == mains_sync_ff[2]) ? mains_sync_ff[2] : mains_ff;
            gens_ff <= (gens_sync_ff[1] == gens_sync_ff[2]) ? gens_sync_ff[2] : gens_ff;
        end
    end

    // =========================================================================
    // Qualifying terms
    assign fn_active = ctrl_ff[`FRT_CTRL_ENABLE] &&
        ((ctrl_ff[`FRT_CTRL_MAINS] && mains_ff) ||
         (ctrl_ff[`FRT_CTRL_GENS] && gens_ff));
    assign below_final = (gen_voltage_i < v_final_ff);
    assign in_event = (state_ff == ST_EVENT);
    // Limit lags elapsed time by one cycle, far below a millisecond step
    assign below_curve = in_event && (gen_voltage_i < curve_limit);
    assign ev_start = fn_active && below_final &&
        ((state_ff == ST_IDLE) || (state_ff == ST_REARM));
    assign ev_cleared = in_event && fn_active && (elapsed_ff >= t_final_ff) &&
        !below_final;
    assign ev_unrecovered = in_event && fn_active && (elapsed_ff >= t_final_ff) &&
        below_final;
    assign lv_rise = in_event && transient_done && !lv_alarm_ff;

    // =========================================================================
    // Event state machine
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (ev_start) begin
                    nxt_state = ST_EVENT;
                end
            end
            ST_EVENT: begin
                if (!fn_active || ev_cleared) begin
                    nxt_state = ST_IDLE;
                end else if (ev_unrecovered) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!ctrl_ff[`FRT_CTRL_ENABLE]) begin
                    nxt_state = ST_IDLE;
                end else if (!below_final) begin
                    nxt_state = ST_REARM;
                end
            end
            ST_REARM: begin
                if (!ctrl_ff[`FRT_CTRL_ENABLE]) begin
                    nxt_state = ST_IDLE;
                end else if (ev_start) begin
                    nxt_state = ST_EVENT;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Elapsed time since the sag began, in milliseconds, saturating
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            presc_ff <= 18'h0_0000;
            tick_ff <= 1'b0;
            elapsed_ff <= 16'h0000;
            lv_alarm_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (ev_start || (presc_ff == TICK_LAST)) begin
                presc_ff <= 18'h0_0000;
            end else begin
                presc_ff <= presc_ff + 18'h0_0001;
            end
            tick_ff <= (presc_ff == TICK_LAST) && !ev_start;
            if (ev_start || !in_event) begin
                elapsed_ff <= 16'h0000;
            end else if (in_event && tick_ff && (elapsed_ff != 16'hFFFF)) begin
                elapsed_ff <= elapsed_ff + 16'h0001;
            end
            // Alarm latches for the rest of the event
            if (nxt_state == ST_IDLE || ev_start) begin
                lv_alarm_ff <= 1'b0;
            end else if (lv_rise) begin
                lv_alarm_ff <= 1'b1;
            end
        end
    end

    frt_curve_limit u_curve (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .elapsed_ms_i(elapsed_ff),
        .t_clear_i(t_clear_ff),
        .t_rec1_i(t_rec1_ff),
        .t_rec2_i(t_rec2_ff),
        .t_rec3_i(t_rec3_ff),
        .v_ret_i(v_ret_ff),
        .v_clear_i(v_clear_ff),
        .v_rec1_i(v_rec1_ff),
        .v_rec2_i(v_rec2_ff),
        .v_final_i(v_final_ff),
        .limit_o(curve_limit)
    );

    frt_delay_timer u_transient (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .tick_i(tick_ff),
        .run_i(below_curve),
        .limit_i(transient_ff),
        .done_o(transient_done)
    );

    // =========================================================================
    // Alarm outputs
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            gen_uv_trip_o <= 1'b0;
            prot_trip_o <= 15'h0000;
            gen_uv_warn_o <= 1'b0;
            warn_o <= 8'h00;
            ride_through_event_alarm_o <= 1'b0;
            gen_low_voltage_alarm_o <= 1'b0;
            suppress_active_o <= 1'b0;
        end else begin
            gen_uv_trip_o <= gen_uv_trip_i &&
                !((nxt_state == ST_EVENT) && !below_curve);
            prot_trip_o <= (nxt_state == ST_EVENT) ? 15'h0000 : prot_trip_i;
            gen_uv_warn_o <= gen_uv_warn_i;
            warn_o <= warn_i;
            ride_through_event_alarm_o <= (nxt_state != ST_IDLE);
            gen_low_voltage_alarm_o <= lv_alarm_ff || lv_rise;
            suppress_active_o <= (nxt_state == ST_EVENT);
        end
    end

    // =========================================================================
    // Avalon-MM slave: one wait cycle, then answer
    assign wr_acc = avs_write_i && !avs_waitrequest_o;
    assign cnt_clr = wr_acc && (avs_address_i == `FRT_OFS_CTRL) && avs_byteenable_i[0] &&
        avs_writedata_i[`FRT_CTRL_CNT_CLR];
    assign irq_set = {ev_unrecovered, ev_cleared, lv_rise, ev_start};

    always @* begin
        nxt_rdata = 32'h0000_0000;
        case (avs_address_i)
            `FRT_OFS_CTRL: nxt_rdata[2:0] = ctrl_ff;
            `FRT_OFS_VOLT_RETAINED: nxt_rdata[15:0] = v_ret_ff;
            `FRT_OFS_VOLT_CLEARANCE: nxt_rdata[15:0] = v_clear_ff;
            `FRT_OFS_VOLT_REC1: nxt_rdata[15:0] = v_rec1_ff;
            `FRT_OFS_VOLT_REC2: nxt_rdata[15:0] = v_rec2_ff;
            `FRT_OFS_VOLT_FINAL: nxt_rdata[15:0] = v_final_ff;
            `FRT_OFS_TIME_CLEARANCE: nxt_rdata[15:0] = t_clear_ff;
            `FRT_OFS_TIME_REC1: nxt_rdata[15:0] = t_rec1_ff;
            `FRT_OFS_TIME_REC2: nxt_rdata[15:0] = t_rec2_ff;
            `FRT_OFS_TIME_REC3: nxt_rdata[15:0] = t_rec3_ff;
            `FRT_OFS_TIME_FINAL: nxt_rdata[15:0] = t_final_ff;
            `FRT_OFS_TRANSIENT: nxt_rdata[15:0] = transient_ff;
            `FRT_OFS_STATUS: begin
                nxt_rdata[`FRT_ST_EVENT] = (state_ff != ST_IDLE);
                nxt_rdata[`FRT_ST_SUPPRESS] = in_event;
                nxt_rdata[`FRT_ST_BELOW] = below_curve;
                nxt_rdata[`FRT_ST_LV_ALARM] = lv_alarm_ff;
                nxt_rdata[`FRT_ST_UNRECOVERED] = (state_ff == ST_HOLD) || (state_ff == ST_REARM);
                nxt_rdata[`FRT_ST_ACTIVE] = fn_active;
            end
            `FRT_OFS_COUNT: nxt_rdata[15:0] = count_ff;
            `FRT_OFS_IRQ_STAT: nxt_rdata[3:0] = irq_stat_ff;
            `FRT_OFS_IRQ_MASK: nxt_rdata[3:0] = irq_mask_ff;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
            if (avs_read_i && avs_waitrequest_o) begin
                avs_readdata_o <= nxt_rdata;
            end
        end
    end

    // Register writes, counter and interrupt status
    always @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_ff <= `FRT_CTRL_RST;
            v_ret_ff <= `FRT_VOLT_RST;
            v_clear_ff <= `FRT_VOLT_RST;
            v_rec1_ff <= `FRT_VOLT_RST;
            v_rec2_ff <= `FRT_VOLT_RST;
            v_final_ff <= `FRT_VOLT_RST;
            t_clear_ff <= `FRT_TIME_RST;
            t_rec1_ff <= `FRT_TIME_RST;
            t_rec2_ff <= `FRT_TIME_RST;
            t_rec3_ff <= `FRT_TIME_RST;
            t_final_ff <= `FRT_TIME_RST;
            transient_ff <= `FRT_TIME_RST;
            count_ff <= 16'h0000;
            irq_stat_ff <= 4'h0;
            irq_mask_ff <= `FRT_IRQ_MASK_RST;
            irq_o <= 1'b0;
        end else begin
            if (wr_acc) begin
                case (avs_address_i)
                    `FRT_OFS_CTRL: ctrl_ff <= avs_byteenable_i[0] ?
                        avs_writedata_i[2:0] : ctrl_ff;
                    `FRT_OFS_VOLT_RETAINED: v_ret_ff <= merge16(v_ret_ff,
                        avs_writedata_i, avs_byteenable_i);
                    `FRT_OFS_VOLT_CLEARANCE: v_clear_ff <= merge16(v_clear_ff,
                        avs_writedata_i, avs_byteenable_i);
                    `FRT_OFS_VOLT_REC1: v_rec1_ff <= merge16(v_rec1_ff,
                        avs_writedata_i, avs_byteenable_i);
                    `FRT_OFS_VOLT_REC2: v_rec2_ff <= merge16(v_rec2_ff,
                        avs_writedata_i, avs_byteenable_i);
                    `FRT_OFS_VOLT_FINAL: v_final_ff <= merge16(v_final_ff,
                        avs_writedata_i, avs_byteenable_i);
                    `FRT_OFS_TIME_CLEARANCE: t_clear_ff <= merge16(t_clear_ff,
                        avs_writedata_i, avs_byteenable_i);
                    `FRT_OFS_TIME_REC1: t_rec1_ff <= merge16(t_rec1_ff,
                        avs_writedata_i, avs_byteenable_i);
                    `FRT_OFS_TIME_REC2: t_rec2_ff <= merge16(t_rec2_ff,
                        avs_writedata_i, avs_byteenable_i);
                    `FRT_OFS_TIME_REC3: t_rec3_ff <= merge16(t_rec3_ff,
                        avs_writedata_i, avs_byteenable_i);
                    `FRT_OFS_TIME_FINAL: t_final_ff <= merge16(t_final_ff,
                        avs_writedata_i, avs_byteenable_i);
                    `FRT_OFS_TRANSIENT: transient_ff <= merge16(transient_ff,
                        avs_writedata_i, avs_byteenable_i);
                    `FRT_OFS_IRQ_MASK: irq_mask_ff <= avs_byteenable_i[0] ?
                        avs_writedata_i[3:0] : irq_mask_ff;
                    default: irq_mask_ff <= irq_mask_ff;
                endcase
            end
            // New event beats a same-cycle clear so no activation is lost
            count_ff <= (cnt_clr ? 16'h0000 : count_ff) +
                {15'h0000, ev_start};
            if (wr_acc && (avs_address_i == `FRT_OFS_IRQ_STAT) && avs_byteenable_i[0]) begin
                irq_stat_ff <= (irq_stat_ff & ~avs_writedata_i[3:0]) | irq_set;
            end else begin
                irq_stat_ff <= irq_stat_ff | irq_set;
            end
            irq_o <= |(irq_stat_ff & irq_mask_ff);
        end
    end

endmodule // frt_supervisor
`default_nettype wire

// *** verif/frt_supervisor_checker.sv ***
// Concurrent checks on the ride-through supervisor ports
`timescale 1ns/10ps
`default_nettype none
module frt_supervisor_checker (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Bus handshake
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    // Alarms
    input wire logic [14:0] prot_trip_i,
    input wire logic [14:0] prot_trip_o,
    input wire logic gen_uv_warn_i,
    input wire logic gen_uv_warn_o,
    input wire logic [7:0] warn_i,
    input wire logic [7:0] warn_o,
    input wire logic ride_through_event_alarm_o,
    input wire logic gen_low_voltage_alarm_o,
    input wire logic suppress_active_o
);
    // =========================================================
    // Assertions
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    chk_prot_masked: assert property (suppress_active_o |-> prot_trip_o == 15'h0000)
        else $error("protection trip passed during suppression");
    // Both cycles clear, so a one-cycle skew of suppression cannot fire it
    chk_prot_pass: assert property (!$past(reset_i) && !suppress_active_o
        && !$past(suppress_active_o) |-> prot_trip_o == $past(prot_trip_i))
        else $error("protection trip blocked outside suppression");
    chk_warn_pass: assert property (!$past(reset_i) |-> warn_o == $past(warn_i)
        && gen_uv_warn_o == $past(gen_uv_warn_i))
        else $error("warning not passed through");
    chk_event_start: assert property ($rose(ride_through_event_alarm_o)
        |-> suppress_active_o)
        else $error("event began without suppression");
    chk_suppress_event: assert property (suppress_active_o
        |-> ride_through_event_alarm_o)
        else $error("suppression outside an event");
    chk_lv_in_event: assert property ($rose(gen_low_voltage_alarm_o)
        |-> ride_through_event_alarm_o)
        else $error("low voltage alarm outside an event");
    chk_lv_clear: assert property ($fell(ride_through_event_alarm_o)
        |=> !gen_low_voltage_alarm_o)
        else $error("low voltage alarm outlived the event");
    chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        && !$past(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
        else $error("bus request not answered in one cycle");
    chk_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    cov_event: cover property ($rose(ride_through_event_alarm_o));
    cov_lv: cover property ($rose(gen_low_voltage_alarm_o));
    cov_hold: cover property ($fell(suppress_active_o) && ride_through_event_alarm_o);
endmodule // frt_supervisor_checker
bind frt_supervisor frt_supervisor_checker chk (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .prot_trip_i(prot_trip_i), .prot_trip_o(prot_trip_o), .gen_uv_warn_i(gen_uv_warn_i),
    .gen_uv_warn_o(gen_uv_warn_o), .warn_i(warn_i), .warn_o(warn_o),
    .ride_through_event_alarm_o(ride_through_event_alarm_o),
    .gen_low_voltage_alarm_o(gen_low_voltage_alarm_o), .suppress_active_o(suppress_active_o));
`default_nettype wire

// *** verif/grid_source_model.sv ***
// Generator voltage measurement and parallel status source
`timescale 1ns/10ps
`default_nettype none
module grid_source_model (
    // Clock and commands
    input wire logic core_clk_i,
    input wire logic [15:0] volt_set_i,
    input wire logic [1:0] pins_set_i,
    // Measurement and status pins
    output logic [15:0] volt_o = 16'h03e8,
    output logic [1:0] pins_o = 2'h0
);
    // =========================================================
    // One sample per clock, as a measurement front end delivers
    always @(posedge core_clk_i) begin
        volt_o <= volt_set_i;
        pins_o <= pins_set_i;
    end
endmodule // grid_source_model
`default_nettype wire

// *** verif/frt_supervisor_tb.sv ***
// Self-checking bench of the ride-through supervisor
`timescale 1ns/10ps
`include "frt_map.vh"
`default_nettype none
module frt_supervisor_tb;
    logic clk = 0, rst = 1, rd = 0, wr = 0, uv = 1, uvw = 1, lvw, evt, lva, sup, irq, wt;
    logic [5:0] addr = 0;
    logic [31:0] wdata = 0, q, rdata;
    logic [14:0] prot = 15'h7fff, prot_o;
    logic [7:0] warn = 8'hff, warn_o;
    logic [15:0] vset = 16'h03e8, volt;
    logic [1:0] pset = 2'h2, pins;
    logic uv_o;
    int fail_count = 0, samples_checked = 0, cycles = 0;
    // =========================================================
    // Clock, partner and design
    always #2.5 clk = ~clk;
    grid_source_model src (.core_clk_i(clk), .volt_set_i(vset), .pins_set_i(pset),
        .volt_o(volt), .pins_o(pins));
    frt_supervisor #(.TICK_CYCLES(4)) DUT (.core_clk_i(clk), .reset_i(rst),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
        .mains_parallel_i(pins[0]), .gen_parallel_i(pins[1]), .gen_voltage_i(volt),
        .gen_uv_trip_i(uv), .prot_trip_i(prot), .gen_uv_warn_i(uvw), .warn_i(warn),
        .gen_uv_trip_o(uv_o), .prot_trip_o(prot_o), .gen_uv_warn_o(lvw), .warn_o(warn_o),
        .ride_through_event_alarm_o(evt), .gen_low_voltage_alarm_o(lva),
        .suppress_active_o(sup), .irq_o(irq));
    // =========================================================
    // Tasks
    task finish_test;
        if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Request held until waitrequest is sampled low
    task bus(input logic [5:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wt !== 1'b0) @(posedge clk);
        q = rdata;
        wr <= 0;
        rd <= 0;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            finish_test();
        end
    end
    // =========================================================
    // Scenarios
    initial begin
        cyc(2);
        rst <= 0;
        bus(`FRT_OFS_CTRL, 0, 0); chk("ctrl", q, 0);
        bus(6'h01, 1, 32'h0000_ffff);
        bus(6'h01, 0, 0); chk("unmapped", q, 0);
        for (int i = 0; i < 5; i++) begin
            bus(6'(4 + 4 * i), 1, 32'(100 * (i + 1)));
            bus(6'(24 + 4 * i), 1, 32'(2 * (i + 1)));
        end
        bus(`FRT_OFS_TRANSIENT, 1, 1);
        bus(`FRT_OFS_IRQ_MASK, 1, 32'h0000_000f);
        bus(`FRT_OFS_CTRL, 1, 32'h0000_0003);
        // Sag while only the generator-parallel pin is up: mains mode only
        vset <= 16'h01c2;
        cyc(12); chk("idle evt", evt, 0);
        chk("idle prot", prot_o, 15'h7fff);
        pset <= 2'h3;
        cyc(8); chk("evt", evt, 1);
        chk("sup", sup, 1);
        chk("uv masked", uv_o, 0);
        chk("prot masked", prot_o, 0);
        chk("warn", {lvw, warn_o}, 9'h1ff);
        bus(`FRT_OFS_COUNT, 0, 0); chk("count", q, 1);
        chk("irq", irq, 1);
        bus(`FRT_OFS_IRQ_STAT, 1, 32'h0000_000f);
        cyc(3); chk("irq clr", irq, 0);
        // Final point steps the limit above the sag, final time passes
        cyc(60); chk("lv", lva, 1);
        chk("hold evt", evt, 1);
        chk("hold sup", sup, 0);
        chk("hold prot", {uv_o, prot_o}, 16'hffff);
        vset <= 16'h03e8;
        cyc(6);
        vset <= 16'h01c2;
        cyc(8); chk("rearm sup", sup, 1);
        bus(`FRT_OFS_COUNT, 0, 0); chk("count2", q, 2);
        vset <= 16'h03e8;
        cyc(60); chk("cleared", {evt, sup, lva}, 0);
        bus(`FRT_OFS_CTRL, 1, 32'h0000_000b);
        bus(`FRT_OFS_COUNT, 0, 0); chk("count clr", q, 0);
        bus(`FRT_OFS_CTRL, 0, 0); chk("ctrl rd", q, 3);
        // Generator-parallel mode follows its own pin
        bus(`FRT_OFS_CTRL, 1, 32'h0000_0005);
        bus(`FRT_OFS_STATUS, 0, 0); chk("gen mode", q, 32'h0000_0020);
        pset <= 2'h1;
        cyc(8);
        bus(`FRT_OFS_STATUS, 0, 0); chk("gen pin down", q, 0);
        finish_test();
    end
endmodule // frt_supervisor_tb
`default_nettype wire
